// ===== dv/dpw_host.sv
/*
 Host processor bus model driving the parallel pins.
 Assumes calls are made one at a time from the bench.
*/
`timescale 1ns/1ns
module dpw_host (
   input wire logic clk_in,
   output logic device_select_n_out,
   output logic write_strobe_n_out,
   output logic dest_reg_sel_lo_out,
   output logic dest_reg_sel_hi_out,
   output logic [5:0] channel_addr_out,
   output logic [13:0] parallel_word_out
);
   // ==========================================
   // Idle bus: not selected, strobe high.
   initial begin
      device_select_n_out = 1'b1;
      write_strobe_n_out = 1'b1;
      {dest_reg_sel_hi_out, dest_reg_sel_lo_out} = 2'h0;
      channel_addr_out = 6'h00;
      parallel_word_out = 14'h0000;
   end
   // One write: strobe low three clocks, rise, hold four, then release with flipped lines.
   task automatic put_word(input logic cs_n, input logic [1:0] sel, input logic [5:0] a, input logic [13:0] w);
      @(posedge clk_in);
      device_select_n_out <= cs_n;
      {dest_reg_sel_hi_out, dest_reg_sel_lo_out} <= sel;
      channel_addr_out <= a;
      parallel_word_out <= w;
      write_strobe_n_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      write_strobe_n_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      device_select_n_out <= 1'b1;
      channel_addr_out <= ~a;
      parallel_word_out <= ~w;
   endtask
endmodule

// ===== dv/dpw_top_chk.sv
/*
 Checker of the parallel write port, bound into dpw_top.
 Assumes the host holds pins four clocks past the strobe rise.
*/
`timescale 1ns/1ns
module dpw_top_chk (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic interface_select_pin_in,
   input wire logic device_select_n_in,
   input wire logic dest_reg_sel_lo_in,
   input wire logic dest_reg_sel_hi_in,
   input wire logic [13:0] parallel_word_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic [1:0] avs_response_out,
   input wire logic outputs_live_out,
   input wire logic [13:0] ctrl_word_out,
   input wire logic queue_mode_out
);
   // ==========================================
   // Completed bus accesses, used as triggers.
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_rd_done;
      avs_read_in && !avs_waitrequest_out;
   endsequence
   sequence s_wr_done;
      avs_write_in && !avs_waitrequest_out;
   endsequence
   // Bus answers, then pin effects, then reset behaviour.
   a_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("waitrequest held too long");
   a_unmapped_read: assert property (s_rd_done ##0 (avs_address_in == 10'h3fc) |-> avs_response_out == 2'h2
      && avs_readdata_out == 32'h0) else $error("unmapped read not refused");
   a_wr_refused: assert property (s_wr_done ##0 (avs_address_in != dpw_pkg::OFS_STATUS) |-> avs_response_out == 2'h2)
      else $error("write to read-only place accepted");
   a_read_stands: assert property (!(avs_read_in || avs_write_in) |=> $stable(avs_readdata_out))
      else $error("readdata moved without access");
   a_live_cause: assert property ($rose(outputs_live_out) |-> !$past(device_select_n_in, 3)
      && $past(dest_reg_sel_hi_in, 3) && $past(dest_reg_sel_lo_in, 3)) else $error("outputs live without data write");
   a_ctrl_cause: assert property ($changed(ctrl_word_out) |-> ctrl_word_out == $past(parallel_word_in, 3)
      && !$past(device_select_n_in, 3) && !$past(dest_reg_sel_hi_in, 3) && !$past(dest_reg_sel_lo_in, 3))
      else $error("control word changed without control write");
   a_iface_gate: assert property ($changed(ctrl_word_out) |-> !$past(interface_select_pin_in, 3))
      else $error("write taken while port closed");
   a_queue_fixed: assert property ($past(rstn_in, 8) |-> $stable(queue_mode_out))
      else $error("queue mode changed outside reset");
endmodule
bind dpw_top dpw_top_chk i_dpw_top_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
   .interface_select_pin_in(interface_select_pin_in), .device_select_n_in(device_select_n_in),
   .dest_reg_sel_lo_in(dest_reg_sel_lo_in), .dest_reg_sel_hi_in(dest_reg_sel_hi_in),
   .parallel_word_in(parallel_word_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .avs_response_out(avs_response_out), .outputs_live_out(outputs_live_out), .ctrl_word_out(ctrl_word_out),
   .queue_mode_out(queue_mode_out));

// ===== dv/tb_dpw_top.sv
/*
 Bench of dpw_top: Avalon reads and host pin writes with expected values.
 Assumes dpw_host drives the pins and the checker is bound.
*/
`timescale 1ns/1ns
module tb_dpw_top;
   logic ref_clk_in = 1'b0, rstn_in = 1'b0, interface_select_pin_in = 1'b0, queue_enable_in = 1'b0;
   logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out, outputs_live_out, queue_mode_out;
   logic [9:0] avs_address_in = 10'h000;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
   logic [1:0] avs_response_out, rsp;
   logic [13:0] ctrl_word_out, word;
   logic [5:0] addr;
   logic cs_n, strobe_n, sel_lo, sel_hi;
   int failures = 0, n_checks = 0, cycles = 0;
   // ==========================================
   // Clock, design and host model.
   always #4 ref_clk_in = ~ref_clk_in;
   dpw_top i_dpw_top (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .interface_select_pin_in(interface_select_pin_in),
      .device_select_n_in(cs_n), .write_strobe_n_in(strobe_n), .dest_reg_sel_lo_in(sel_lo),
      .dest_reg_sel_hi_in(sel_hi), .channel_addr_in(addr), .parallel_word_in(word), .queue_enable_in(queue_enable_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .avs_response_out(avs_response_out),
      .outputs_live_out(outputs_live_out), .ctrl_word_out(ctrl_word_out), .queue_mode_out(queue_mode_out));
   dpw_host i_dpw_host (.clk_in(ref_clk_in), .device_select_n_out(cs_n), .write_strobe_n_out(strobe_n),
      .dest_reg_sel_lo_out(sel_lo), .dest_reg_sel_hi_out(sel_hi), .channel_addr_out(addr), .parallel_word_out(word));
   // Report and stop.
   task automatic end_sim;
      $display("checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Compare one value.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // One Avalon access, held until waitrequest is seen low.
   task automatic av(input logic wr, input logic [9:0] a, input logic [31:0] wd);
      @(posedge ref_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= wd;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      rsp = avs_response_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   // Read with expected data and response.
   task automatic rdc(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
      av(1'b0, a, 32'h0);
      chk("readdata", e, rd);
      chk("response", {30'h0, er}, {30'h0, rsp});
   endtask
   // Hang guard.
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         end_sim;
      end
   end
   // Main sequence.
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      rdc(dpw_pkg::OFS_STATUS, 32'h1, 2'h0);
      rdc(10'h29c, {18'h0, dpw_pkg::GAIN_RST}, 2'h0);
      rdc(dpw_pkg::OFS_OFFSET_BASE, {18'h0, dpw_pkg::OFFSET_RST}, 2'h0);
      i_dpw_host.put_word(1'b0, dpw_pkg::SEL_DATA, 6'd0, 14'h2abc);
      i_dpw_host.put_word(1'b0, dpw_pkg::SEL_GAIN, 6'd39, 14'h1234);
      i_dpw_host.put_word(1'b0, dpw_pkg::SEL_OFFSET, 6'd5, 14'h0001);
      i_dpw_host.put_word(1'b0, dpw_pkg::SEL_SPECIAL, dpw_pkg::CTRL_ADDR, 14'h3001);
      i_dpw_host.put_word(1'b1, dpw_pkg::SEL_DATA, 6'd1, 14'h1111);
      i_dpw_host.put_word(1'b0, dpw_pkg::SEL_DATA, 6'd40, 14'h0555);
      repeat (6) @(posedge ref_clk_in);
      rdc(dpw_pkg::OFS_DATA_BASE, 32'h2abc, 2'h0);
      rdc(10'h29c, 32'h1234, 2'h0);
      rdc(10'h314, 32'h0001, 2'h0);
      rdc(dpw_pkg::OFS_CTRL, 32'h3001, 2'h0);
      rdc(10'h104, 32'h0, 2'h0);
      rdc(dpw_pkg::OFS_STATUS, 32'hd, 2'h0);
      rdc(dpw_pkg::OFS_WCOUNT, 32'h5, 2'h0);
      chk("outputs_live_out", 32'h1, {31'h0, outputs_live_out});
      chk("ctrl_word_out", 32'h3001, {18'h0, ctrl_word_out});
      av(1'b1, dpw_pkg::OFS_STATUS, 32'h8);
      chk("response", 32'h0, {30'h0, rsp});
      av(1'b1, dpw_pkg::OFS_CTRL, 32'h0);
      chk("response", 32'h2, {30'h0, rsp});
      rdc(10'h3fc, 32'h0, 2'h2);
      interface_select_pin_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      i_dpw_host.put_word(1'b0, dpw_pkg::SEL_DATA, 6'd2, 14'h0fff);
      repeat (6) @(posedge ref_clk_in);
      rdc(10'h108, 32'h0, 2'h0);
      rdc(dpw_pkg::OFS_STATUS, 32'h5, 2'h0);
      interface_select_pin_in <= 1'b0;
      queue_enable_in <= 1'b1;
      rstn_in <= 1'b0;
      repeat (8) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      rdc(dpw_pkg::OFS_STATUS, 32'h3, 2'h0);
      rdc(dpw_pkg::OFS_DATA_BASE, 32'h0, 2'h0);
      rdc(10'h29c, {18'h0, dpw_pkg::GAIN_RST}, 2'h0);
      chk("outputs_live_out", 32'h0, {31'h0, outputs_live_out});
      chk("queue_mode_out", 32'h1, {31'h0, queue_mode_out});
      end_sim;
   end
endmodule

// ===== rtl/dpw_pin_capture.sv
/*
 File: pin synchroniser and strobe edge detector of the parallel port.
 Assumes: pins are asynchronous to ref_clk_in; strobe high and low last
 at least three clock periods each so that every edge is seen.
*/
`timescale 1ns/1ns
module dpw_pin_capture (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic device_select_n_in,
   input wire logic write_strobe_n_in,
   input wire logic interface_select_pin_in,
   input wire dpw_pkg::dpw_xfer_s xfer_in,
   output logic write_pulse_out,
   output dpw_pkg::dpw_xfer_s xfer_out
);
   // ==========================================================
   // Two-stage synchronisers
   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   dpw_pkg::dpw_xfer_s xmeta_ff;
   dpw_pkg::dpw_xfer_s xsync_ff;
   logic strobe_old_ff;
   wire strobe_rise = sync_ff[1] & ~strobe_old_ff;
   wire cs_low = ~sync_ff[0];
   wire par_mode = ~sync_ff[2];

   // All pins pass two flops before any logic reads them.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_ff <= 3'h7;
         sync_ff <= 3'h7;
         xmeta_ff <= '0;
         xsync_ff <= '0;
         strobe_old_ff <= 1'b1;
      end else begin
         meta_ff <= {interface_select_pin_in, write_strobe_n_in, device_select_n_in};
         sync_ff <= meta_ff;
         xmeta_ff <= xfer_in;
         xsync_ff <= xmeta_ff;
         strobe_old_ff <= sync_ff[1];
      end
   end

   // Rising strobe edge qualified by select and parallel mode.
   assign write_pulse_out = strobe_rise & cs_low & par_mode;
   assign xfer_out = xsync_ff;
endmodule

// ===== rtl/dpw_pkg.sv
/*
 File: package for the parallel write port of a 40-channel 14-bit converter.
 Assumes: included first in compile order; all users write dpw_pkg::name.
*/
// Overview of operation
// - Parallel port works only while interface select low.
// - Device select is active low.
// - Write strobe rising edge captures channel address.
// - Same edge loads word into selected register.
// - Destination select picks register type of channel.
// - Each of 40 channels individually writable.
// - Fourteen-bit straight binary word, top line MSB.
// - After reset registers default, outputs stay zero.
// - Hardware reset reloads every register default.
// - Select zero, address 001100 writes control register.
// - Queue mode needs parallel port, sampled at reset.
package dpw_pkg;
   // ==========================================================
   // Sizes
   localparam int unsigned CHANNELS = 40;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 14;
   localparam int unsigned SEL_W = 2;
   // ==========================================================
   // Destination codes and the control register address
   localparam logic [1:0] SEL_SPECIAL = 2'h0;
   localparam logic [1:0] SEL_GAIN = 2'h1;
   localparam logic [1:0] SEL_OFFSET = 2'h2;
   localparam logic [1:0] SEL_DATA = 2'h3;
   localparam logic [5:0] CTRL_ADDR = 6'h0c;
   // ==========================================================
   // Reset values
   localparam logic [13:0] DATA_RST = 14'h0000;
   localparam logic [13:0] GAIN_RST = 14'h3ffe;
   localparam logic [13:0] OFFSET_RST = 14'h2000;
   localparam logic [13:0] CTRL_RST = 14'h0000;
   // ==========================================================
   // Register bus offsets (byte addresses)
   localparam logic [9:0] OFS_STATUS = 10'h000;
   localparam logic [9:0] OFS_CTRL = 10'h004;
   localparam logic [9:0] OFS_WCOUNT = 10'h008;
   localparam logic [9:0] OFS_DATA_BASE = 10'h100;
   localparam logic [9:0] OFS_GAIN_BASE = 10'h200;
   localparam logic [9:0] OFS_OFFSET_BASE = 10'h300;
   // Status bit positions.
   localparam int unsigned ST_PAR_BIT = 0;
   localparam int unsigned ST_QUEUE_BIT = 1;
   localparam int unsigned ST_WRITTEN_BIT = 2;
   localparam int unsigned ST_ERR_BIT = 3;

   // One captured parallel transfer.
   typedef struct packed {
      logic [1:0] sel;
      logic [5:0] addr;
      logic [13:0] word;
   } dpw_xfer_s;
endpackage

// ===== rtl/dpw_top.sv
/*
 File: parallel write port with channel register file and Avalon-MM view.
 Assumes: the host holds address, select and data steady around the strobe
 rising edge for at least three clock periods; one clock, ref_clk_in.
*/
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ns
module dpw_top (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic interface_select_pin_in,
   input wire logic device_select_n_in,
   input wire logic write_strobe_n_in,
   input wire logic dest_reg_sel_lo_in,
   input wire logic dest_reg_sel_hi_in,
   input wire logic [5:0] channel_addr_in,
   input wire logic [13:0] parallel_word_in,
   input wire logic queue_enable_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic [1:0] avs_response_out,
   output logic outputs_live_out,
   output logic [13:0] ctrl_word_out,
   output logic queue_mode_out
);
   // ==========================================================
   // Reset release
   logic [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];

   // Reset asserts at once and releases through two flops.
   // Every other flop of the block, except the strap synchroniser, is reset by this released copy.
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   // ==========================================================
   // Pin capture
   logic wr_pulse;
   dpw_pkg::dpw_xfer_s xfer;
   dpw_pkg::dpw_xfer_s pins;
   assign pins.sel = {dest_reg_sel_hi_in, dest_reg_sel_lo_in};
   assign pins.addr = channel_addr_in;
   assign pins.word = parallel_word_in;

   dpw_pin_capture i_dpw_pin_capture (
      .clk_in(ref_clk_in),
      .rstn_in(rst_n),
      .device_select_n_in(device_select_n_in),
      .write_strobe_n_in(write_strobe_n_in),
      .interface_select_pin_in(interface_select_pin_in),
      .xfer_in(pins),
      .write_pulse_out(wr_pulse),
      .xfer_out(xfer)
   );

   // ==========================================================
   // Write decode
   // A write past channel 39, or with select zero away from the control address, writes no register but flags an error and is counted.
   wire addr_ok = xfer.addr < 6'(dpw_pkg::CHANNELS);
   wire is_ctrl = (xfer.sel == dpw_pkg::SEL_SPECIAL) && (xfer.addr == dpw_pkg::CTRL_ADDR);
   wire wr_ctrl = wr_pulse & is_ctrl;
   wire wr_chan = wr_pulse & addr_ok & (xfer.sel != dpw_pkg::SEL_SPECIAL);
   wire wr_bad = wr_pulse & ~is_ctrl & ~(addr_ok & (xfer.sel != dpw_pkg::SEL_SPECIAL));
   wire [5:0] ch = xfer.addr;

   // Channel register arrays, three types per channel.
   logic [13:0] data_mem [0:dpw_pkg::CHANNELS-1];
   logic [13:0] gain_mem [0:dpw_pkg::CHANNELS-1];
   logic [13:0] ofs_mem [0:dpw_pkg::CHANNELS-1];
   logic [13:0] ctrl_ff;
   logic live_ff;
   logic written_ff;
   logic err_ff;
   logic queue_ff;
   logic par_ff;
   logic strap_done_ff;
   logic [15:0] wcount_ff;
   logic bus_clr_err;

   // Every register reloads its default on reset.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < dpw_pkg::CHANNELS; i++) begin
            data_mem[i] <= dpw_pkg::DATA_RST;
            gain_mem[i] <= dpw_pkg::GAIN_RST;
            ofs_mem[i] <= dpw_pkg::OFFSET_RST;
         end
      end else if (wr_chan) begin
         case (xfer.sel)
            dpw_pkg::SEL_DATA: data_mem[ch] <= xfer.word;
            dpw_pkg::SEL_OFFSET: ofs_mem[ch] <= xfer.word;
            dpw_pkg::SEL_GAIN: gain_mem[ch] <= xfer.word;
            default: data_mem[ch] <= data_mem[ch];
         endcase
      end
   end

   // Control state, write counter, written and error flags and outputs-live flag.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= dpw_pkg::CTRL_RST;
         live_ff <= 1'b0;
         written_ff <= 1'b0;
         err_ff <= 1'b0;
         wcount_ff <= 16'h0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= xfer.word;
         end
         if (wr_chan && xfer.sel == dpw_pkg::SEL_DATA) begin
            live_ff <= 1'b1;
         end
         if (wr_pulse) begin
            written_ff <= 1'b1;
            wcount_ff <= wcount_ff + 16'h0001;
         end
         if (wr_bad) begin
            err_ff <= 1'b1;
         end else if (bus_clr_err) begin
            err_ff <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Strap synchroniser
   logic [1:0] strap_meta_ff;
   logic [1:0] strap_sync_ff;

   // The strap pins are asynchronous, so they pass two flops before the capture.
   // No reset here: the flops fill during the two-edge reset release.
   always_ff @(posedge ref_clk_in) begin
      strap_meta_ff <= {queue_enable_in, interface_select_pin_in};
      strap_sync_ff <= strap_meta_ff;
   end

   // Queue enable and mode strap caught once after reset release.
   // Only a further reset can change the queue mode afterwards.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_ff <= 1'b0;
         queue_ff <= 1'b0;
         par_ff <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         par_ff <= ~strap_sync_ff[0];
         queue_ff <= strap_sync_ff[1] & ~strap_sync_ff[0];
      end
   end

   // ==========================================================
   // Avalon-MM slave: one wait cycle, then read data registered
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [1:0] resp_ff;
   wire req = avs_read_in | avs_write_in;
   wire [9:0] a = avs_address_in;
   wire [5:0] idx = a[7:2];
   wire idx_ok = idx < 6'(dpw_pkg::CHANNELS);
   wire in_data = (a[9:8] == dpw_pkg::OFS_DATA_BASE[9:8]) && idx_ok;
   wire in_gain = (a[9:8] == dpw_pkg::OFS_GAIN_BASE[9:8]) && idx_ok;
   wire in_ofs = (a[9:8] == dpw_pkg::OFS_OFFSET_BASE[9:8]) && idx_ok;
   assign bus_clr_err = ack_ff & avs_write_in & (a == dpw_pkg::OFS_STATUS)
                        & avs_byteenable_in[0] & avs_writedata_in[dpw_pkg::ST_ERR_BIT];
   wire [31:0] status_word = {28'h0000000, err_ff, written_ff, queue_ff, par_ff};
   logic [31:0] nxt_rdata;
   logic nxt_hit;

   // Read mux over status, control, counter and channel arrays.
   always_comb begin
      nxt_hit = 1'b1;
      nxt_rdata = 32'h00000000;
      if (a == dpw_pkg::OFS_STATUS) begin
         nxt_rdata = status_word;
      end else if (a == dpw_pkg::OFS_CTRL) begin
         nxt_rdata = {18'h00000, ctrl_ff};
      end else if (a == dpw_pkg::OFS_WCOUNT) begin
         nxt_rdata = {16'h0000, wcount_ff};
      end else if (in_data) begin
         nxt_rdata = {18'h00000, data_mem[idx]};
      end else if (in_gain) begin
         nxt_rdata = {18'h00000, gain_mem[idx]};
      end else if (in_ofs) begin
         nxt_rdata = {18'h00000, ofs_mem[idx]};
      end else begin
         nxt_hit = 1'b0;
      end
   end

   // Request is held until the acknowledging cycle.
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         resp_ff <= 2'h0;
      end else begin
         ack_ff <= req & ~ack_ff;
         if (req & ~ack_ff) begin
            rdata_ff <= avs_read_in ? nxt_rdata : 32'h00000000;
            resp_ff <= (nxt_hit & ~(avs_write_in & a != dpw_pkg::OFS_STATUS)) ? 2'h0 : 2'h2;
         end
      end
   end

   // Waitrequest is combinational; every other output comes from a register.
   assign avs_waitrequest_out = req & ~ack_ff;
   assign avs_readdata_out = rdata_ff;
   assign avs_response_out = resp_ff;
   assign outputs_live_out = live_ff;
   assign ctrl_word_out = ctrl_ff;
   assign queue_mode_out = queue_ff;
endmodule
